/* src/rsq_reset_sequencer.v */
/*
  Internal reset state machine with its vulnerable release window and
  prescaler-update window; a reset landing in either locks the device
  in reset until power is cycled.
  Assumes all inputs synchronous to i_ref_clk; i_nrst stands for the
  power-on reset, so only it clears the stuck condition.
*/
`timescale 1ns/100ps
`include "rsq_defines.vh"

module rsq_reset_sequencer #(
  parameter STARTUP_CYCLES = `RSQ_STARTUP_CYCLES,
  parameter VULN_CYCLES = `RSQ_VULN_CYCLES
) (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire i_ext_rst_n,
  input wire i_wdt_rst,
  input wire i_bod_rst,
  input wire i_prog_mode,
  input wire i_presc_wr,
  output reg o_core_rst_n,
  output reg o_stuck,
  output reg o_vulnerable,
  output reg o_prog_rst
);
  localparam [2:0] ST_HOLD = `RSQ_ST_HOLD;
  localparam [2:0] ST_DELAY = `RSQ_ST_DELAY;
  localparam [2:0] ST_VULN = `RSQ_ST_VULN;
  localparam [2:0] ST_RUN = `RSQ_ST_RUN;
  localparam [2:0] ST_STUCK = `RSQ_ST_STUCK;

  // last count of a run of n cycles, cut to the counter width
  function [`RSQ_CNT_W-1:0] last_of;
    input integer n;
    integer t;
    begin
      t = n - 1;
      last_of = t[`RSQ_CNT_W-1:0];
    end
  endfunction

  // counter step; every run ends well below the top of the counter
  function [`RSQ_CNT_W-1:0] cnt_step;
    input [`RSQ_CNT_W-1:0] v;
    begin
      cnt_step = v + {{(`RSQ_CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  localparam [`RSQ_CNT_W-1:0] STARTUP_LAST = last_of(STARTUP_CYCLES);
  localparam [`RSQ_CNT_W-1:0] VULN_LAST = last_of(VULN_CYCLES);

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`RSQ_CNT_W-1:0] cnt;
  reg [`RSQ_CNT_W-1:0] next_cnt;
  reg [`RSQ_CNT_W-1:0] pcnt;
  reg [`RSQ_CNT_W-1:0] next_pcnt;
  reg presc_win;
  reg next_presc_win;
  reg next_core_rst_n;
  reg next_stuck;
  reg next_vulnerable;
  reg prog_pulse;
  wire prog_exit;
  wire any_rst;

  rsq_edge_det u_prog_edge (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_level(i_prog_mode),
    .o_rise(),
    .o_fall(prog_exit)
  );

  // leaving programming raises a one-cycle internal reset
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      prog_pulse <= 1'b0;
    end else begin
      prog_pulse <= prog_exit;
    end
  end

  assign any_rst = ~i_ext_rst_n | i_wdt_rst | i_bod_rst | prog_pulse;

  // prescaler update window, next value
  always @* begin
    next_presc_win = presc_win;
    next_pcnt = pcnt;
    if (i_presc_wr && state == ST_RUN) begin
      next_presc_win = 1'b1;
      next_pcnt = {`RSQ_CNT_W{1'b0}};
    end else if (presc_win) begin
      if (pcnt == VULN_LAST) begin
        next_presc_win = 1'b0;
      end
      next_pcnt = cnt_step(pcnt);
    end
  end

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      presc_win <= 1'b0;
      pcnt <= {`RSQ_CNT_W{1'b0}};
    end else begin
      presc_win <= next_presc_win;
      pcnt <= next_pcnt;
    end
  end

  always @* begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ST_HOLD: begin
        next_cnt = {`RSQ_CNT_W{1'b0}};
        if (!any_rst) begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (any_rst) begin
          next_state = ST_HOLD;
          next_cnt = {`RSQ_CNT_W{1'b0}};
        end else if (cnt == STARTUP_LAST) begin
          next_state = ST_VULN;
          next_cnt = {`RSQ_CNT_W{1'b0}};
        end else begin
          next_cnt = cnt_step(cnt);
        end
      end
      ST_VULN: begin
        if (any_rst) begin
          next_state = ST_STUCK;
        end else if (cnt == VULN_LAST) begin
          next_state = ST_RUN;
        end else begin
          next_cnt = cnt_step(cnt);
        end
      end
      ST_RUN: begin
        if (any_rst && presc_win) begin
          next_state = ST_STUCK;
        end else if (any_rst) begin
          next_state = ST_HOLD;
        end
      end
      ST_STUCK: begin
        next_state = ST_STUCK;
      end
      default: begin
        next_state = ST_HOLD;
        next_cnt = {`RSQ_CNT_W{1'b0}};
      end
    endcase
  end

  // output values follow the state and window of the next cycle
  always @* begin
    next_core_rst_n = (next_state == ST_RUN);
    next_stuck = (next_state == ST_STUCK);
    next_vulnerable = (next_state == ST_VULN) ||
      (next_state == ST_RUN && next_presc_win);
  end

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      state <= ST_HOLD;
      cnt <= {`RSQ_CNT_W{1'b0}};
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // outputs straight from flops, aligned with state and window
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_core_rst_n <= 1'b0;
      o_stuck <= 1'b0;
      o_vulnerable <= 1'b0;
      o_prog_rst <= 1'b0;
    end else begin
      o_core_rst_n <= next_core_rst_n;
      o_stuck <= next_stuck;
      o_vulnerable <= next_vulnerable;
      o_prog_rst <= prog_exit;
    end
  end
endmodule

/* src/rsq_defines.vh */
/*
  Constants for the reset state sequencer: state codes, timing figures
  and derived cycle counts.
  Assumes a 125 MHz system clock; included by bare name.
*/
`ifndef RSQ_DEFINES_VH
`define RSQ_DEFINES_VH

`define RSQ_CLK_PERIOD_PS 8000
`define RSQ_VULN_TIME_PS 10000
// longest time rounds down, never below one cycle
`define RSQ_VULN_CYCLES ((`RSQ_VULN_TIME_PS / `RSQ_CLK_PERIOD_PS) < 1 ? 1 : \
  (`RSQ_VULN_TIME_PS / `RSQ_CLK_PERIOD_PS))
`define RSQ_STARTUP_CYCLES 64
`define RSQ_CNT_W 16

`define RSQ_ST_HOLD 3'h0
`define RSQ_ST_DELAY 3'h1
`define RSQ_ST_VULN 3'h2
`define RSQ_ST_RUN 3'h3
`define RSQ_ST_STUCK 3'h4

`endif

/* src/rsq_edge_det.v */
/*
  Edge detector: one-cycle pulse on o_rise for a low-to-high change and on
  o_fall for a high-to-low change of the input level.
  Assumes the input is synchronous to the clock.
*/
`timescale 1ns/100ps
module rsq_edge_det (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire i_level,
  output wire o_rise,
  output wire o_fall
);
  reg prev;

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      prev <= 1'b0;
    end else begin
      prev <= i_level;
    end
  end

  assign o_rise = i_level & ~prev;
  assign o_fall = ~i_level & prev;
endmodule

/* test/rsq_props.sv */
/* checker on the sequencer ports
   bound to the top module by name */
`timescale 1ns/100ps
module rsq_props (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire i_ext_rst_n,
  input wire i_wdt_rst,
  input wire i_bod_rst,
  input wire i_prog_mode,
  input wire o_core_rst_n,
  input wire o_stuck,
  input wire o_vulnerable,
  input wire o_prog_rst
);
  wire src = !i_ext_rst_n | i_wdt_rst | i_bod_rst;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_calm;
    o_vulnerable && !o_core_rst_n && !src && !o_prog_rst;
  endsequence
  a_vuln_lock:
    assert property (o_vulnerable && src |=> o_stuck) else $error("no lock");
  a_calm_rel:
    assert property (s_calm |=> o_core_rst_n) else $error("no release");
  a_prog_pulse:
    assert property ($fell(i_prog_mode) && !o_stuck |-> ##[1:2] o_prog_rst)
      else $error("no pulse");
  a_stuck_hold:
    assert property (o_stuck |=> o_stuck && !o_core_rst_n) else $error("left");
  a_src_drop:
    assert property (o_core_rst_n && src |=> !o_core_rst_n) else $error("run");
  a_rel_vuln:
    assert property ($rose(o_core_rst_n) |-> $past(o_vulnerable))
      else $error("early");
endmodule
bind rsq_reset_sequencer rsq_props u_props (.*);

/* test/rsq_src.sv */
/* reset sources and programming line
   selected by the bench */
`timescale 1ns/100ps
module rsq_src (
  input wire i_ref_clk,
  input wire [2:0] i_sel,
  input wire i_arm,
  input wire i_vuln,
  output wire [3:0] o_src
);
  logic [3:0] q;
  // one source at a time, level follows the select
  always_comb
    q = (i_sel == 3'h0) ? 4'h0 : 4'h1 << (i_sel - 3'h1);
  // armed: hit the open window
  assign o_src = q | {1'h0, i_arm & i_vuln, 2'h0};
endmodule

/* test/testbench.sv */
/* bench for the sequencer
   sources come from rsq_src */
`timescale 1ns/100ps
module testbench;
  localparam S = 4;
  localparam V = 1;
  logic i_ref_clk = 1'h0;
  logic i_nrst = 1'h0;
  logic i_presc_wr = 1'h0;
  logic arm = 1'h0;
  logic [2:0] sel = 3'h0;
  wire [3:0] src;
  wire core_n, stuck, vuln, prst;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  rsq_src SRC (.i_ref_clk(i_ref_clk), .i_sel(sel), .i_arm(arm),
    .i_vuln(vuln), .o_src(src));
  rsq_reset_sequencer #(.STARTUP_CYCLES(S), .VULN_CYCLES(V)) DUT (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ext_rst_n(!src[0]),
    .i_wdt_rst(src[1]), .i_bod_rst(src[2]), .i_prog_mode(src[3]),
    .i_presc_wr(i_presc_wr), .o_core_rst_n(core_n), .o_stuck(stuck),
    .o_vulnerable(vuln), .o_prog_rst(prst));
  initial forever #4 i_ref_clk = ~i_ref_clk;
  task results;
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      results();
    end
  end
  task chk(string nm, int e, logic [7:0] g);
    n_compared++;
    if (g !== e[7:0]) begin
      bad_count++;
      $display("mismatch %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task go(int s, int len);
    sel = s[2:0];
    repeat (len) @(negedge i_ref_clk);
    sel = 3'h0;
  endtask
  task rel;
    n = 0;
    while (core_n !== 1'h1 && n < 60) begin
      @(negedge i_ref_clk);
      n++;
    end
  endtask
  task rst;
    i_nrst = 1'h0;
    arm = 1'h0;
    repeat (12) @(negedge i_ref_clk);
    i_nrst = 1'h1;
    rel();
    chk("rel_cycles", S + V + 1, n);
  endtask
  initial begin
    void'($urandom(32'hFFBF5913));
    rst();
    for (int s = 1; s < 4; s++) begin
      go(s, 3 + $urandom % 3);
      chk("core_n", 0, core_n);
      rel();
      chk("stuck", 0, stuck);
    end
    go(4, 4);
    n = 0;
    repeat (6) begin
      @(negedge i_ref_clk);
      n += prst;
    end
    chk("prog_rst", 1, n);
    rel();
    arm = 1'h1;
    i_presc_wr = 1'h1;
    @(negedge i_ref_clk);
    chk("vuln_presc", 1, vuln);
    i_presc_wr = 1'h0;
    repeat (3) @(negedge i_ref_clk);
    chk("stuck_presc", 1, stuck);
    go(2, 4);
    chk("core_held", 0, core_n);
    rst();
    arm = 1'h1;
    go(2, 3);
    repeat (S + V + 6) @(negedge i_ref_clk);
    chk("stuck_vuln", 1, stuck);
    rst();
    results();
  end
endmodule
